// ===== pkg/cutt_consts.svh
// Constants for the core up/down timer with toggle latch.
// Assumes a 16-bit register port with word offsets.
`ifndef CUTT_CONSTS_SVH
`define CUTT_CONSTS_SVH
`define CUTT_OFF_CTRL 4'h0
`define CUTT_OFF_COUNT 4'h1
`define CUTT_OFF_AUX 4'h2
`define CUTT_OFF_STATUS 4'h3
`define CUTT_CTRL_RESET 16'h0000
`define CUTT_MODE_TIMER 3'h0
`define CUTT_MODE_COUNTER 3'h1
`define CUTT_MODE_GATED_LO 3'h2
`define CUTT_MODE_GATED_HI 3'h3
`define CUTT_EDGE_NONE 3'h0
`define CUTT_EDGE_RISE 3'h1
`define CUTT_EDGE_FALL 3'h2
`define CUTT_EDGE_BOTH 3'h3
`define CUTT_BIT_OTL 10
`define CUTT_BIT_AUX_RC 9
`endif

// ===== pkg/cutt_pkg.sv
// Types for the core up/down timer with toggle latch.
// Assumes nothing beyond the constants header.
package cutt_pkg;
    typedef struct packed {
        logic [2:0] unused_hi;
        logic [1:0] block_prescaler_select;
        logic overflow_toggle_latch;
        logic toggle_output_enable;
        logic external_direction_enable;
        logic direction_bit;
        logic core_run_bit;
        logic [2:0] core_mode_field;
        logic [2:0] input_parameter_field;
    } cutt_ctrl_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } cutt_bus_s;
    typedef struct packed {
        logic otl;
        logic shadow;
        logic run;
    } cutt_aux_s;
    typedef enum logic [1:0] {CUTT_TIMER, CUTT_COUNTER, CUTT_GATED, CUTT_IDLE} cutt_mode_e;
endpackage : cutt_pkg

// ===== hdl/cutt_core_timer.sv
// Core 16-bit up/down timer with overflow toggle latch and shadow latch.
// Assumes pins synchronous to core_clk and a one-cycle register port.
//
// How it works
// - Run bit starts and stops the core timer in modes 000 to 011; modes 1XX never count.
// - Gated mode advances only when run bit is 1 and gate active.
// - With remote select, core run bit also runs auxiliary timer.
// - External enable 0: direction bit alone, 0 up, 1 down.
// - External enable 1: down when pin XOR direction bit, else up.
// - Direction changes take effect at once, running or not.
// - Overflow or underflow toggles latch; shadow follows; both go to aux.
// - Shadow equals toggle latch delayed one clock cycle.
// - Software write sets both latches together, no edge seen.
// - Output enable 1 drives latch state; 0 drives pin high.
// - Overflow/underflow pulse goes out to compare/capture timers.
// - Mode 000 timer mode, clocked by both prescalers.
// - Modes 010/011 gated; bit 0 picks gate active level.
// - Gated mode uses same prescaled ticks, passed only while gate active.
// - Gate level changes raise no interrupt request.
// - Mode 001 counter mode: one step per selected pin edge.
// - Input 000 off, 001 rising, 010 falling, 011 both; 1XX reserved.
// - Block prescaler: 00 div4, 01 div2, 10 div16, 11 div8.
// - Software write to count beats simultaneous hardware update.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`include "cutt_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module cutt_core_timer #(
    parameter int WIDTH = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire cutt_pkg::cutt_bus_s bus,
    output logic [15:0] rdata,
    input wire logic gate_count_input_pin,
    input wire logic external_direction_pin,
    output logic toggle_output_pin,
    output logic overflow_underflow_pulse,
    output cutt_pkg::cutt_aux_s aux_out
);
    import cutt_pkg::*;

    ////////////////////////////////////////////////////////////////////
    cutt_ctrl_s ctrl_reg;
    logic [WIDTH-1:0] count_reg;
    logic aux_remote_run_select_reg;
    logic shadow_reg;
    logic [10:0] pre_reg;
    logic pin_prev_reg;
    logic tick_reg;
    logic [15:0] rdata_reg;
    logic count_down;
    logic gate_active;
    logic pre_tick;
    logic edge_hit;
    logic step;
    logic wrap;
    logic [3:0] base_log;
    logic [4:0] div_log;
    cutt_mode_e mode;
    logic count_wr;
    logic ctrl_wr;
    logic aux_wr;

    // One decode per written register, shared by the write paths and some checks; the others decode bus.addr again
    assign count_wr = bus.wr && (bus.addr == `CUTT_OFF_COUNT);
    assign ctrl_wr = bus.wr && (bus.addr == `CUTT_OFF_CTRL);
    assign aux_wr = bus.wr && (bus.addr == `CUTT_OFF_AUX);

    always_comb begin
        case (ctrl_reg.core_mode_field)
            `CUTT_MODE_TIMER: mode = CUTT_TIMER;
            `CUTT_MODE_COUNTER: mode = CUTT_COUNTER;
            `CUTT_MODE_GATED_LO, `CUTT_MODE_GATED_HI: mode = CUTT_GATED;
            default: mode = CUTT_IDLE;
        endcase
    end

    // Direction is combinational so it applies immediately
    assign count_down = ctrl_reg.external_direction_enable
        ? (external_direction_pin ^ ctrl_reg.direction_bit)
        : ctrl_reg.direction_bit;

    // Gate level compare; no interrupt path exists for it
    assign gate_active = (gate_count_input_pin == ctrl_reg.core_mode_field[0]);

    ////////////////////////////////////////////////////////////////////
    // Prescaler: block factor then input factor 2^input_parameter
    always_comb begin
        case (ctrl_reg.block_prescaler_select)
            2'h0: base_log = 4'h2;
            2'h1: base_log = 4'h1;
            2'h2: base_log = 4'h4;
            default: base_log = 4'h3;
        endcase
    end
    assign div_log = {1'b0, base_log} + {2'h0, ctrl_reg.input_parameter_field};
    // Eleven bits cover the largest factor, 16 times 2^7
    assign pre_tick = (pre_reg & ((11'h001 << div_log) - 11'h001)) == 11'h000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_reg <= 11'h000;
        end else begin
            pre_reg <= pre_reg + 11'h001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick_reg <= 1'b0;
        end else begin
            // Ticks at every multiple, the wrap of pre_reg included
            tick_reg <= pre_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Count pin edge detection
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= gate_count_input_pin;
        end
    end

    always_comb begin
        case (ctrl_reg.input_parameter_field)
            `CUTT_EDGE_RISE: edge_hit = gate_count_input_pin & ~pin_prev_reg;
            `CUTT_EDGE_FALL: edge_hit = ~gate_count_input_pin & pin_prev_reg;
            `CUTT_EDGE_BOTH: edge_hit = gate_count_input_pin ^ pin_prev_reg;
            default: edge_hit = 1'b0;
        endcase
    end

    always_comb begin
        case (mode)
            CUTT_TIMER: step = ctrl_reg.core_run_bit & tick_reg;
            CUTT_GATED: step = ctrl_reg.core_run_bit & gate_active & tick_reg;
            CUTT_COUNTER: step = ctrl_reg.core_run_bit & edge_hit;
            default: step = 1'b0;
        endcase
    end

    // A count write in the same cycle cancels the step and so the wrap
    assign wrap = step & ~count_wr & (count_down ? (count_reg == '0) : (&count_reg));

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (count_wr) begin
            count_reg <= bus.wdata[WIDTH-1:0];
        end else if (step) begin
            count_reg <= count_down ? count_reg - 1'b1 : count_reg + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CUTT_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= bus.wdata;
        end else if (wrap) begin
            ctrl_reg.overflow_toggle_latch <= ~ctrl_reg.overflow_toggle_latch;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shadow_reg <= 1'b0;
        end else if (ctrl_wr) begin
            shadow_reg <= bus.wdata[`CUTT_BIT_OTL];
        end else begin
            shadow_reg <= ctrl_reg.overflow_toggle_latch;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aux_remote_run_select_reg <= 1'b0;
        end else if (aux_wr) begin
            aux_remote_run_select_reg <= bus.wdata[`CUTT_BIT_AUX_RC];
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            toggle_output_pin <= 1'b1;
            overflow_underflow_pulse <= 1'b0;
            aux_out <= '0;
        end else begin
            toggle_output_pin <= ctrl_reg.toggle_output_enable
                ? ctrl_reg.overflow_toggle_latch : 1'b1;
            overflow_underflow_pulse <= wrap;
            aux_out.otl <= ctrl_reg.overflow_toggle_latch;
            aux_out.shadow <= shadow_reg;
            aux_out.run <= aux_remote_run_select_reg & ctrl_reg.core_run_bit;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr)
                `CUTT_OFF_CTRL: rdata_reg <= ctrl_reg;
                `CUTT_OFF_COUNT: rdata_reg <= 16'(count_reg);
                `CUTT_OFF_AUX: rdata_reg <= {6'h00, aux_remote_run_select_reg, 9'h000};
                `CUTT_OFF_STATUS: rdata_reg <= {14'h0000, shadow_reg, count_down};
                default: rdata_reg <= 16'h0000;
            endcase
        end
    end
    assign rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////
    AST_STOPPED_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_reg.core_run_bit && !(bus.wr && bus.addr == `CUTT_OFF_COUNT)
        |=> count_reg == $past(count_reg)) else $error("count moved while stopped");
    AST_GATE_HOLDS: assert property (@(posedge core_clk) disable iff (rst)
        mode == CUTT_GATED && !gate_active && !(bus.wr && bus.addr == `CUTT_OFF_COUNT)
        |=> count_reg == $past(count_reg)) else $error("count moved with gate shut");
    AST_DIR_SW: assert property (@(posedge core_clk) disable iff (rst)
        step && !count_wr && !ctrl_reg.external_direction_enable
        |=> count_reg == ($past(ctrl_reg.direction_bit)
            ? $past(count_reg) - 1'b1 : $past(count_reg) + 1'b1))
        else $error("direction wrong");
    AST_DIR_EXT: assert property (@(posedge core_clk) disable iff (rst)
        step && !count_wr && ctrl_reg.external_direction_enable
        |=> count_reg == (($past(external_direction_pin) ^ $past(ctrl_reg.direction_bit))
            ? $past(count_reg) - 1'b1 : $past(count_reg) + 1'b1))
        else $error("external direction wrong");
    AST_SHADOW_LAG: assert property (@(posedge core_clk) disable iff (rst)
        !$past(bus.wr && bus.addr == `CUTT_OFF_CTRL)
        |-> shadow_reg == $past(ctrl_reg.overflow_toggle_latch))
        else $error("shadow not one cycle late");
    AST_SW_NO_EDGE: assert property (@(posedge core_clk) disable iff (rst)
        bus.wr && bus.addr == `CUTT_OFF_CTRL
        |=> shadow_reg == ctrl_reg.overflow_toggle_latch) else $error("write left mismatch");
    AST_WRAP_TOGGLE: assert property (@(posedge core_clk) disable iff (rst)
        wrap && !ctrl_wr
        |=> ctrl_reg.overflow_toggle_latch != $past(ctrl_reg.overflow_toggle_latch)
            && overflow_underflow_pulse) else $error("wrap did not toggle");
    AST_OUT_HIGH: assert property (@(posedge core_clk) disable iff (rst)
        !ctrl_reg.toggle_output_enable |=> toggle_output_pin) else $error("pin not high");
    AST_SW_WINS: assert property (@(posedge core_clk) disable iff (rst)
        bus.wr && bus.addr == `CUTT_OFF_COUNT |=> count_reg == $past(bus.wdata))
        else $error("software write lost");
    AST_SW_SETS_LATCH: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_wr
        |=> ctrl_reg.overflow_toggle_latch == $past(bus.wdata[`CUTT_BIT_OTL]))
        else $error("latch write lost");

    ////////////////////////////////////////////////////////////////////
    // Counting only on the selected event, and the wrap at both ends
    AST_RUN_STEPS: assert property (@(posedge core_clk) disable iff (rst)
        mode == CUTT_TIMER && ctrl_reg.core_run_bit && tick_reg && !count_wr
        |=> count_reg != $past(count_reg))
        else $error("running timer missed a tick");
    AST_GATE_RUNS: assert property (@(posedge core_clk) disable iff (rst)
        mode == CUTT_GATED && ctrl_reg.core_run_bit && gate_active && tick_reg && !count_wr
        |=> count_reg != $past(count_reg))
        else $error("open gate missed a tick");
    AST_TICK_ONLY: assert property (@(posedge core_clk) disable iff (rst)
        mode != CUTT_COUNTER && !tick_reg && !count_wr
        |=> count_reg == $past(count_reg))
        else $error("count moved between ticks");
    AST_EDGE_ONLY: assert property (@(posedge core_clk) disable iff (rst)
        mode == CUTT_COUNTER && !edge_hit && !count_wr
        |=> count_reg == $past(count_reg))
        else $error("count moved without pin edge");
    AST_WRAP_UP: assert property (@(posedge core_clk) disable iff (rst)
        step && !count_wr && !count_down && (&count_reg)
        |=> count_reg == '0 && overflow_underflow_pulse)
        else $error("no overflow at top");
    AST_WRAP_DOWN: assert property (@(posedge core_clk) disable iff (rst)
        step && !count_wr && count_down && (count_reg == '0)
        |=> (&count_reg) && overflow_underflow_pulse)
        else $error("no underflow at zero");

    ////////////////////////////////////////////////////////////////////
    // Outputs against the state they copy
    AST_PULSE_SOURCE: assert property (@(posedge core_clk) disable iff (rst)
        overflow_underflow_pulse |-> $past(wrap))
        else $error("pulse without wrap");
    AST_OUT_FOLLOWS: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_reg.toggle_output_enable
        |=> toggle_output_pin == $past(ctrl_reg.overflow_toggle_latch))
        else $error("pin not showing latch");
    AST_AUX_COPY: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> aux_out.otl == $past(ctrl_reg.overflow_toggle_latch)
            && aux_out.shadow == $past(shadow_reg))
        else $error("aux latch copy wrong");
    AST_AUX_RUN: assert property (@(posedge core_clk) disable iff (rst)
        1'b1
        |=> aux_out.run == ($past(aux_remote_run_select_reg)
            && $past(ctrl_reg.core_run_bit)))
        else $error("aux run wrong");
    AST_RDATA_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
        bus.rd && bus.addr > `CUTT_OFF_STATUS |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
endmodule : cutt_core_timer
`default_nettype wire

// ===== bench/cutt_pin_model.sv
// Far-side pin model: gate/count and external direction inputs.
// Assumes the bench asks for levels and keeps each one long enough.
`timescale 1ns/100ps
`default_nettype none
module cutt_pin_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic gate_req,
    input wire logic dir_req,
    output logic gate_count_input_pin,
    output logic external_direction_pin
);
    // Pins are plain inputs of the device, driven only from here
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_count_input_pin <= 1'b0;
            external_direction_pin <= 1'b0;
        end else begin
            gate_count_input_pin <= gate_req;
            external_direction_pin <= dir_req;
        end
    end
endmodule : cutt_pin_model
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the core up/down timer.
// Assumes the design header and package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cutt_pkg::*;
    logic core_clk = 0;
    logic rst = 1;
    cutt_bus_s bus = '0;
    logic [15:0] rdata;
    logic gate_req = 0;
    logic dir_req = 0;
    logic gate_pin;
    logic dir_pin;
    logic toggle_output_pin;
    logic overflow_underflow_pulse;
    cutt_aux_s aux_out;
    logic [15:0] rv;
    logic prev;
    logic [15:0] hold;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    int e;
    int d;
    int f;
    cutt_core_timer i_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .gate_count_input_pin(gate_pin), .external_direction_pin(dir_pin),
        .toggle_output_pin(toggle_output_pin),
        .overflow_underflow_pulse(overflow_underflow_pulse), .aux_out(aux_out));
    cutt_pin_model i_pins (.core_clk(core_clk), .rst(rst), .gate_req(gate_req),
        .dir_req(dir_req), .gate_count_input_pin(gate_pin), .external_direction_pin(dir_pin));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd
    function automatic logic [15:0] ctl(logic [1:0] bps, logic otl, logic oe, logic ude,
        logic ud, logic run, logic [2:0] m, logic [2:0] ip);
        return {3'h0, bps, otl, oe, ude, ud, run, m, ip};
    endfunction : ctl
    initial begin
        tick(6);
        rst <= 1'b0;
        rd(4'h0);
        chk(rv, 16'h0000);
        chk(toggle_output_pin, 1'b1);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        chk(rv, 16'h0000);
        rd(4'h0);
        chk(rv, 16'h0000);
        $display("test reset done");
        for (k = 0; k < 8; k++) begin
            dir_req <= k[2];
            wr(4'h0, ctl(2'h0, 1'b0, 1'b0, k[1], k[0], k[2], 3'h0, 3'h0));
            tick(3);
            rd(4'h3);
            chk(rv[0], k[1] ? (k[2] ^ k[0]) : k[0]);
        end
        wr(4'h0, 16'h0000);
        $display("test direction done");
        for (d = 0; d < 2; d++) begin
            wr(4'h1, d ? 16'h0001 : 16'hFFFE);
            wr(4'h0, ctl(2'h1, d[0], 1'b1, 1'b0, d[0], 1'b1, 3'h0, 3'h0));
            k = 0;
            while (overflow_underflow_pulse !== 1'b1 && k < 100) begin
                @(posedge core_clk);
                #1 k++;
            end
            chk(k < 100, 1'b1);
            for (e = 0; e < 6; e++) begin
                prev = aux_out.otl;
                @(posedge core_clk);
                #1 chk(aux_out.shadow, prev);
            end
            chk(aux_out.otl, d ? 1'b0 : 1'b1);
            chk(toggle_output_pin, d ? 1'b0 : 1'b1);
            wr(4'h0, ctl(2'h1, 1'b1, 1'b0, 1'b0, d[0], 1'b0, 3'h0, 3'h0));
            @(posedge core_clk);
            #1 chk(aux_out.shadow, 1'b1);
            chk(aux_out.otl, 1'b1);
            rd(4'h1);
            chk(d ? rv > 16'hFFF0 : rv < 16'h0010, 1'b1);
            hold = rv;
            tick(20);
            rd(4'h1);
            chk(rv, hold);
            chk(toggle_output_pin, 1'b1);
            chk(aux_out.otl, aux_out.shadow);
        end
        $display("test wrap done");
        wr(4'h2, 16'h0200);
        wr(4'h0, ctl(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 3'h0));
        tick(3);
        chk(aux_out.run, 1'b1);
        wr(4'h0, 16'h0000);
        tick(3);
        chk(aux_out.run, 1'b0);
        $display("test remote run done");
        for (e = 0; e < 4; e++) begin
            wr(4'h1, 16'h0000);
            wr(4'h0, ctl(2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1, e[2:0]));
            repeat (2) begin
                gate_req <= 1'b1;
                tick(6);
                gate_req <= 1'b0;
                tick(6);
            end
            rd(4'h1);
            chk(rv, e == 3 ? 16'h0004 : (e == 0 ? 16'h0000 : 16'h0002));
        end
        $display("test counter done");
        for (k = 0; k < 4; k++) begin
            gate_req <= k[0];
            wr(4'h1, 16'h0000);
            wr(4'h0, ctl(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, {2'b01, k[1]}, 3'h0));
            tick(40);
            wr(4'h0, 16'h0000);
            rd(4'h1);
            chk(rv != 16'h0000, k[0] == k[1]);
        end
        $display("test gated done");
        for (k = 0; k < 6; k++) begin
            f = (k == 0) ? 4 : (k == 1) ? 2 : (k == 2) ? 16 : (k == 5) ? 32 : 8;
            wr(4'h1, 16'h0000);
            wr(4'h0, ctl(k < 4 ? k[1:0] : k[1:0] + 2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0,
                k == 4 ? 3'h2 : (k == 5 ? 3'h1 : 3'h0)));
            tick(96);
            wr(4'h0, 16'h0000);
            rd(4'h1);
            chk(rv >= 96 / f - 1 && rv <= 96 / f + 2, 1'b1);
        end
        $display("test prescaler done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
